// File: design/rcbp_map.svh
// Constants for the registered command buffer: widths, bit masks, resets.
// Assumes inclusion by bare name from the package and design modules.
`ifndef RCBP_MAP_SVH
`define RCBP_MAP_SVH

// Buffered word width, bit 0 standing for input position 1
`define RCBP_WIDTH 28
// Active positions with the configuration pin low: 1-5, 7, 9-12, 17-28
`define RCBP_MASK_A 28'hFFF0F5F
// Active positions with the configuration pin high: 1-12, 17-20, 22, 24-28
`define RCBP_MASK_B 28'hFAF0FFF
// Reset values
`define RCBP_WORD_RST 28'h0000000
`define RCBP_BIT_LOW 1'h0
`define RCBP_FAIL_N_RST 1'h1

`endif

// File: design/rcbp_pkg.sv
// Types shared by the registered command buffer modules.
// Assumes rcbp_map.svh is on the include path.
`include "rcbp_map.svh"

package rcbp_pkg;
  typedef logic [`RCBP_WIDTH-1:0] rcbp_word_t;
  // Parity error output state: clear, first low cycle, later low cycles
  typedef enum logic [1:0] {
    RCBP_ERR_CLEAR = 2'b00,
    RCBP_ERR_LOW1 = 2'b01,
    RCBP_ERR_LOW2 = 2'b10
  } rcbp_err_state_t;
endpackage

// File: design/rcbp_par_if.sv
// Link between the buffer datapath and its parity checker.
// Assumes both ends run on the same clock and reset.
interface rcbp_par_if;
  logic word_par;   // Parity of the word registered at the last capture
  logic word_valid; // A capture took place at the last edge
  logic parity_bit; // Parity input as presented now
  logic sel_idle;   // Both rank selects high at this edge
  logic fail_n;     // Registered parity error, active low
  modport datapath (output word_par, output word_valid, output parity_bit,
    output sel_idle, input fail_n);
  modport checker_end (input word_par, input word_valid, input parity_bit,
    input sel_idle, output fail_n);
endinterface

// File: design/rcbp_parity.sv
// Parity checker: pairs a captured word with the parity bit of the next
// edge and drives the latched, active-low error result.
// Assumes the datapath registers word parity and valid at capture.
`include "rcbp_map.svh"

module rcbp_parity (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Datapath link
  rcbp_par_if.checker_end par
);

  logic err_reg;
  logic err_next;
  rcbp_pkg::rcbp_err_state_t state_reg;
  rcbp_pkg::rcbp_err_state_t state_next;
  logic fail_n_reg;
  logic fail_n_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next values: edge n+1 compares, edge n+2 drives the result
  always_comb begin
    // Even parity over the active word and the late parity bit
    err_next = par.word_valid & (par.word_par ^ par.parity_bit);
    state_next = state_reg;
    if (!par.sel_idle) begin
      unique case (state_reg)
        rcbp_pkg::RCBP_ERR_CLEAR: if (err_reg) state_next = rcbp_pkg::RCBP_ERR_LOW1;
        rcbp_pkg::RCBP_ERR_LOW1: state_next = rcbp_pkg::RCBP_ERR_LOW2;
        rcbp_pkg::RCBP_ERR_LOW2: begin
          // Back-to-back errors keep the output low for their duration
          state_next = err_reg ? rcbp_pkg::RCBP_ERR_LOW2 : rcbp_pkg::RCBP_ERR_CLEAR;
        end
        default: state_next = rcbp_pkg::RCBP_ERR_CLEAR;
      endcase
    end
    fail_n_next = (state_next == rcbp_pkg::RCBP_ERR_CLEAR);
  end

  // Registers; reset holds the error output high
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      err_reg <= `RCBP_BIT_LOW;
      state_reg <= rcbp_pkg::RCBP_ERR_CLEAR;
      fail_n_reg <= `RCBP_FAIL_N_RST;
    end else begin
      err_reg <= err_next;
      state_reg <= state_next;
      fail_n_reg <= fail_n_next;
    end
  end

  assign par.fail_n = fail_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  fail_min_low_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $fell(fail_n_reg) |=> !fail_n_reg)
    else $error("parity error output released after one cycle");

  fail_gated_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    par.sel_idle |=> $stable(fail_n_reg))
    else $error("parity error output changed while both selects high");

  fail_timing_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (par.word_valid && (par.word_par != par.parity_bit)) ##1 !par.sel_idle
      |=> !fail_n_reg)
    else $error("parity mismatch not reported two edges after capture");

endmodule

// File: design/rcbp_top.sv
// Registered command buffer with chip-select gating and delayed parity check.
// Assumes all inputs synchronous to clock_in, whose rising edge stands for
// the true clock rising; the complementary clock is sampled as an input.
`include "rcbp_map.svh"

module rcbp_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clock_complement_in,
  // Static configuration and gating
  input wire logic config_select_in,
  input wire logic select_gating_enable_in,
  // Command inputs from the controller
  input wire logic [`RCBP_WIDTH-1:0] buffered_inputs_in,
  input wire logic rank_select0_in_n,
  input wire logic rank_select1_in_n,
  input wire logic termination_ctrl0_in,
  input wire logic termination_ctrl1_in,
  input wire logic clk_enable_ctrl0_in,
  input wire logic clk_enable_ctrl1_in,
  input wire logic parity_bit_in,
  // Registered outputs to the memory devices
  output logic [`RCBP_WIDTH-1:0] buffered_outputs_out,
  output logic rank_select0_out_n,
  output logic rank_select1_out_n,
  output logic termination_ctrl0_out,
  output logic termination_ctrl1_out,
  output logic clk_enable_ctrl0_out,
  output logic clk_enable_ctrl1_out,
  // Parity error, active low
  output logic parity_fail_n_out
);

  rcbp_pkg::rcbp_word_t mask;
  rcbp_pkg::rcbp_word_t word_reg;
  rcbp_pkg::rcbp_word_t word_next;
  logic sel0_n_reg;
  logic sel0_n_next;
  logic sel1_n_reg;
  logic sel1_n_next;
  logic [1:0] term_reg;
  logic [1:0] term_next;
  logic [1:0] cke_reg;
  logic [1:0] cke_next;
  logic par_reg;
  logic par_next;
  logic valid_reg;
  logic valid_next;
  logic crossing;
  logic sel_idle;
  logic capture;

  rcbp_par_if par ();

  ////////////////////////////////////////////////////////////////////////////
  // Edge qualification and gating
  // The complement must be low at the true clock's rise; otherwise the edge
  // is no crossing: word, select and control registers hold, valid_reg clears.
  assign crossing = !clock_complement_in;
  assign sel_idle = rank_select0_in_n & rank_select1_in_n;
  // Gating only bites when enabled and both selects are high
  assign capture = crossing & !(select_gating_enable_in & sel_idle);

  // Active bit positions; the pin is meant to be strapped, not switched
  assign mask = config_select_in ? `RCBP_MASK_B : `RCBP_MASK_A;

  ////////////////////////////////////////////////////////////////////////////
  // Data word next value, one slice per bit position
  genvar i;
  generate
    for (i = 0; i < `RCBP_WIDTH; i = i + 1) begin : g_bit
      // Unused positions read low; suppressed capture keeps the old bit
      always_comb begin
        if (!mask[i]) begin
          word_next[i] = `RCBP_BIT_LOW;
        end else if (capture) begin
          word_next[i] = buffered_inputs_in[i];
        end else begin
          word_next[i] = word_reg[i];
        end
      end
    end
  endgenerate

  // Parity of the captured word; it stays with the word until the next one
  always_comb begin
    par_next = par_reg;
    valid_next = capture;
    if (capture) begin
      // Selects and control bits never enter this sum
      par_next = ^(buffered_inputs_in & mask);
    end
  end

  // Controls and selects follow every crossing, never gated
  always_comb begin
    sel0_n_next = sel0_n_reg;
    sel1_n_next = sel1_n_reg;
    term_next = term_reg;
    cke_next = cke_reg;
    if (crossing) begin
      sel0_n_next = rank_select0_in_n;
      sel1_n_next = rank_select1_in_n;
      term_next = {termination_ctrl1_in, termination_ctrl0_in};
      cke_next = {clk_enable_ctrl1_in, clk_enable_ctrl0_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; asynchronous reset drives every output low at once, except parity_fail_n_out, which goes high
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      word_reg <= `RCBP_WORD_RST;
      sel0_n_reg <= `RCBP_BIT_LOW;
      sel1_n_reg <= `RCBP_BIT_LOW;
      term_reg <= {2{`RCBP_BIT_LOW}};
      cke_reg <= {2{`RCBP_BIT_LOW}};
      par_reg <= `RCBP_BIT_LOW;
      valid_reg <= `RCBP_BIT_LOW;
    end else begin
      word_reg <= word_next;
      sel0_n_reg <= sel0_n_next;
      sel1_n_reg <= sel1_n_next;
      term_reg <= term_next;
      cke_reg <= cke_next;
      par_reg <= par_next;
      valid_reg <= valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity checker; the controller sends parity one edge late
  assign par.word_par = par_reg;
  assign par.word_valid = valid_reg;
  assign par.parity_bit = parity_bit_in;
  assign par.sel_idle = sel_idle;

  rcbp_parity u_parity (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .par(par.checker_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop
  assign buffered_outputs_out = word_reg;
  assign rank_select0_out_n = sel0_n_reg;
  assign rank_select1_out_n = sel1_n_reg;
  assign termination_ctrl0_out = term_reg[0];
  assign termination_ctrl1_out = term_reg[1];
  assign clk_enable_ctrl0_out = cke_reg[0];
  assign clk_enable_ctrl1_out = cke_reg[1];
  assign parity_fail_n_out = par.fail_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  data_capture_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (crossing && !sel_idle) |=> buffered_outputs_out == $past(buffered_inputs_in & mask))
    else $error("data not captured at a crossing with a select low");

  gated_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (select_gating_enable_in && sel_idle) |=> $stable(buffered_outputs_out))
    else $error("data outputs changed while gated");

  ungated_capture_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (crossing && !select_gating_enable_in)
      |=> buffered_outputs_out == $past(buffered_inputs_in & mask))
    else $error("data not redriven with gating disabled");

  ctrl_redrive_a: assert property (@(posedge clock_in) disable iff (rst_in)
    crossing |=> {termination_ctrl1_out, termination_ctrl0_out, clk_enable_ctrl1_out,
      clk_enable_ctrl0_out, rank_select1_out_n, rank_select0_out_n}
      == $past({termination_ctrl1_in, termination_ctrl0_in, clk_enable_ctrl1_in,
      clk_enable_ctrl0_in, rank_select1_in_n, rank_select0_in_n}))
    else $error("control outputs not redriven at a crossing");

  unused_low_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $stable(config_select_in) |-> (buffered_outputs_out & ~mask) == `RCBP_WORD_RST)
    else $error("inactive data position driven high");

  reset_state_a: assert property (@(posedge clock_in)
    rst_in |-> (buffered_outputs_out == `RCBP_WORD_RST) && parity_fail_n_out
      && !rank_select0_out_n && !rank_select1_out_n && !termination_ctrl0_out)
    else $error("outputs not at reset values during reset");

  reset_ctrl_low_a: assert property (@(posedge clock_in)
    rst_in |-> !termination_ctrl1_out && !clk_enable_ctrl0_out && !clk_enable_ctrl1_out)
    else $error("control outputs not low during reset");

  reset_internal_a: assert property (@(posedge clock_in)
    rst_in |-> !valid_reg && !par_reg)
    else $error("internal parity state not cleared during reset");

  no_crossing_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !crossing |=> $stable({buffered_outputs_out, rank_select1_out_n, rank_select0_out_n,
      termination_ctrl1_out, termination_ctrl0_out, clk_enable_ctrl1_out,
      clk_enable_ctrl0_out}))
    else $error("outputs changed at an edge that was no crossing");

  word_parity_a: assert property (@(posedge clock_in) disable iff (rst_in)
    capture |=> par_reg == $past(^(buffered_inputs_in & mask)))
    else $error("parity of the captured word is wrong");

endmodule

// File: testbench/rcbp_ctrl_model.sv
// Memory controller model: drives command, selects and delayed parity.
// Assumes bench requests change just after the rising clock edge.
`include "rcbp_map.svh"

////////////////////////////////////////////////////////////////////////
module rcbp_ctrl_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Requests from the bench
  input wire logic cfg_in,
  input wire rcbp_pkg::rcbp_word_t word_in,
  input wire logic [1:0] sel_n_in,
  input wire logic [3:0] ctl_in,
  input wire logic corrupt_in,
  // Lines to the buffer
  output rcbp_pkg::rcbp_word_t word_out,
  output logic [1:0] sel_n_out,
  output logic [3:0] ctl_out,
  output logic parity_out
);
  timeunit 1ns;
  timeprecision 1ns;
  rcbp_pkg::rcbp_word_t mask;

  // Command lines pass straight through; the bench already times them
  assign mask = cfg_in ? `RCBP_MASK_B : `RCBP_MASK_A;
  assign word_out = word_in;
  assign sel_n_out = sel_n_in;
  assign ctl_out = ctl_in;

  // Parity lags its word by one clock; low in reset to avoid false errors
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      parity_out <= 1'h0;
    end else begin
      parity_out <= ^(word_in & mask) ^ corrupt_in;
    end
  end
endmodule

// File: testbench/tb.sv
// Testbench for the registered command buffer with parity check.
// Assumes the controller model and design files are compiled first.
`include "rcbp_map.svh"

////////////////////////////////////////////////////////////////////////
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock starts high and reset rises before the first rising edge, so
  // no edge ever sees unreset outputs
  logic clock_in = 1'h1;
  logic rst_in = 1'h0;
  logic comp = 1'h0;
  logic cfg = 1'h0;
  logic gate = 1'h0;
  logic corrupt = 1'h0;
  logic [27:0] word = 28'h0;
  logic [1:0] sel_n = 2'h0;
  logic [3:0] ctl = 4'h0;
  logic [27:0] m_word;
  logic [27:0] e_q;
  logic [1:0] m_sel;
  logic [3:0] m_ctl;
  logic [5:0] e_sc;
  logic m_par, e_fail, v1, errp, c_prev;
  logic [31:0] r, r2;
  logic [34:0] act;
  logic [34:0] notes[$];
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 39;
  int cnt;

  // Clock at 20 MHz
  always #25 clock_in = ~clock_in;

  rcbp_ctrl_model u_rcbp_ctrl_model (.clock_in(clock_in), .rst_in(rst_in),
    .cfg_in(cfg), .word_in(word), .sel_n_in(sel_n), .ctl_in(ctl),
    .corrupt_in(corrupt), .word_out(m_word), .sel_n_out(m_sel),
    .ctl_out(m_ctl), .parity_out(m_par));

  rcbp_top u_rcbp_top (.clock_in(clock_in), .rst_in(rst_in),
    .clock_complement_in(comp), .config_select_in(cfg),
    .select_gating_enable_in(gate), .buffered_inputs_in(m_word),
    .rank_select0_in_n(m_sel[0]), .rank_select1_in_n(m_sel[1]),
    .termination_ctrl0_in(m_ctl[3]), .termination_ctrl1_in(m_ctl[2]),
    .clk_enable_ctrl0_in(m_ctl[1]), .clk_enable_ctrl1_in(m_ctl[0]),
    .parity_bit_in(m_par), .buffered_outputs_out(act[34:7]),
    .rank_select0_out_n(act[5]), .rank_select1_out_n(act[6]),
    .termination_ctrl0_out(act[4]), .termination_ctrl1_out(act[3]),
    .clk_enable_ctrl0_out(act[2]), .clk_enable_ctrl1_out(act[1]),
    .parity_fail_n_out(act[0]));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [34:0] ex, input logic [34:0] ac);
    comparisons++;
    if (ac !== ex) begin
      mismatches++;
      $display("[ERR] %0t exp %h got %h", $time, ex, ac);
    end
  endtask

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Drive one edge and note its expected outputs; ends at edge plus 1 ns
  task automatic step(input logic [27:0] w, input logic [1:0] s,
    input logic [3:0] c, input logic g, input logic bad, input logic cx);
    word = w;
    sel_n = s;
    ctl = c;
    gate = g;
    corrupt = bad;
    comp = cx;
    if (!cx) begin
      // Error state: 0 clear, 1 first low cycle, 2 later low cycles
      if (!(&s)) begin
        if (cnt == 0) cnt = errp ? 1 : 0;
        else if (cnt == 1) cnt = 2;
        else cnt = errp ? 2 : 0;
        e_fail = (cnt == 0);
      end
      errp = v1 & c_prev;
      v1 = !(g && (&s));
      if (v1) e_q = w & (cfg ? `RCBP_MASK_B : `RCBP_MASK_A);
      e_sc = {s, c};
      c_prev = bad;
    end
    @(posedge clock_in);
    #1;
    notes.push_back({e_q, e_sc, e_fail});
  endtask

  // Mid-cycle asynchronous reset, checked before any clock edge
  task automatic do_reset(input logic c);
    #30;
    notes.delete();
    rst_in = 1'h1;
    #2;
    chk({28'h0, 6'h0, 1'h1}, act);
    {cfg, word, sel_n, ctl, corrupt, comp} = {c, 36'h0};
    {e_q, e_sc, e_fail, v1, errp, c_prev} = {34'h0, 1'h1, 3'h0};
    cnt = 0;
    repeat (8) @(posedge clock_in);
    #1;
    rst_in = 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Results settle by the falling edge; oldest note is compared
  always @(negedge clock_in) begin
    if (!rst_in && notes.size() > 0) chk(notes.pop_front(), act);
  end

  // Hang guard, well above the roughly 190 cycles used
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end

  // Per configuration: hold edge, random traffic, errors, gated-mode capture with a select low
  initial begin
    for (int i = 0; i < 2; i++) begin
      do_reset(i[0]);
      repeat (3) step(28'h0, 2'h0, 4'h0, 1'h0, 1'h0, 1'h0);
      r = $random(seed);
      step(28'h0, r[1:0], r[5:2], 1'h1, 1'h0, 1'h1);
      repeat (60) begin
        r = $random(seed);
        r2 = $random(seed);
        step(r[27:0], r2[1:0], r2[5:2], r2[6], 1'h0, 1'h0);
      end
      for (int k = 0; k < 17; k++) begin
        r = $random(seed);
        step(r[27:0], {2{k inside {11, 12}}}, r[31:28], 1'h1,
          1'(17'h103C9 >> k), 1'h0);
      end
      step(r[27:0], 2'h0, 4'h0, 1'h1, 1'h0, 1'h0);
      step(r[27:0], 2'h1, 4'h0, 1'h1, 1'h0, 1'h0);
    end
    do_reset(1'h0);
    end_sim();
  end
endmodule
